// ---- logic/dsfe_stream_engine.v ----
// streaming fifo engine: output/input fifos, port drive, host buffer tracking
// Behaviour
// R1 - fifo at half level during streaming raises refill request to host
// R2 - ports keep last written value when fifo empties or data ends
// R3 - output fifo holds 2k entries, 24 bits, low 16 port data
// R4 - input fifo holds 1k entries, 24 bits, low 16 input data
// R5 - with expansion memory fitted output fifo depth is 64k entries
// R6 - one direction bit per port; one drives, zero tri-states
// R7 - host uses only low 4 or 8 mask bits, rest zero
// R8 - tagged output word: low 16 data, bits 16-18 select port
// R9 - tagged input counter values occupy low 24 bits of word
// R10 - tagged format honoured only when fixed-list dma flag is clear
// R11 - fixed-list dma uses 1, 2, 4 or 8 ports, up to 1600 khz
// R12 - list modes accept any list but output capped at 450 khz
// R13 - dma first list entry is start port, rest consecutive
// R14 - host keeps frames at least 512 input or 1024 output samples
// R15 - frame end signals frame-complete event
// R16 - without wrap stop at buffer end, set complete and halted
// R17 - with wrap continue from buffer start
// R18 - with overwrite reuse locations though host has not refreshed them; code does this for the input fifo only
// R19 - host sets directions and mode, preloads, then starts
// R20 - exactly one port update or read per sample clock pulse
// R21 - all ports are inputs after reset
// R22 - refill request issued once per crossing of half depth
// R23 - run begins only on start; stop halts, ports keep values
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "dsfe_defines.vh"
module dsfe_stream_engine #(
  parameter OUT_AW = 16,
  parameter IN_AW = 10,
  parameter EXT_MEM = 1
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire [127:0] port_pin_i,
  output reg [127:0] port_pin_o,
  output reg [127:0] port_pin_oe_o,
  output reg refill_req_o,
  output reg frame_complete_event_o,
  output reg buffer_complete_event_o,
  output reg run_halted_event_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_HALT = 2'd2;
  localparam [31:0] DMA_FLOOR = (`DSFE_CLK_KHZ + `DSFE_DMA_MAX_KHZ - 1) / `DSFE_DMA_MAX_KHZ;
  localparam [31:0] LIST_FLOOR = (`DSFE_CLK_KHZ + `DSFE_LIST_MAX_KHZ - 1) / `DSFE_LIST_MAX_KHZ;
  localparam [31:0] OUT_DEPTH_STD = `DSFE_OUT_DEPTH; // see R3
  localparam [31:0] OUT_DEPTH_BIG = `DSFE_OUT_DEPTH_EXT; // see R5
  localparam [31:0] IN_DEPTH_W = `DSFE_IN_DEPTH; // see R4
  reg [31:0] ctrl_r;
  reg [7:0] port_direction_mask;
  reg [31:0] out_list_r, in_list_r;
  reg [31:0] buf_len_r, frame_len_r;
  reg [15:0] divider_r;
  reg [1:0] out_state_r, in_state_r;
  reg [`DSFE_ENTRY_W-1:0] out_mem [0:(1<<OUT_AW)-1];
  reg [`DSFE_ENTRY_W-1:0] in_mem [0:(1<<IN_AW)-1];
  reg [OUT_AW:0] out_wp_r, out_rp_r;
  reg [IN_AW:0] in_wp_r, in_rp_r;
  reg [31:0] out_pos_r, in_pos_r, out_frame_r, in_frame_r;
  reg [2:0] out_idx_r, in_idx_r;
  reg [127:0] port_latch_r;
  reg [127:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stable_r;
  reg out_half_r, in_half_r, out_sticky_r, in_sticky_r;
  wire out_tick, in_tick;
  wire [OUT_AW:0] out_level = out_wp_r - out_rp_r;
  wire [IN_AW:0] in_level = in_wp_r - in_rp_r;
  wire [31:0] out_level_x = {{(31-OUT_AW){1'b0}}, out_level};
  wire [31:0] in_level_x = {{(31-IN_AW){1'b0}}, in_level};
  // usable output depth follows the expansion memory strap and control bit
  wire ext_on = (EXT_MEM != 0) && ctrl_r[`DSFE_C_EXTMEM];
  wire [OUT_AW:0] out_depth = ext_on ? OUT_DEPTH_BIG[OUT_AW:0] : OUT_DEPTH_STD[OUT_AW:0];
  wire [IN_AW:0] in_depth = IN_DEPTH_W[IN_AW:0]; // see R4
  wire out_dma = ctrl_r[`DSFE_C_OUT_DMA];
  wire in_dma = ctrl_r[`DSFE_C_IN_DMA];
  wire out_tag = ctrl_r[`DSFE_C_TAGGED] && !out_dma; // see R10
  wire in_tag = ctrl_r[`DSFE_C_TAGGED] && !in_dma; // see R10
  wire out_full = out_level >= out_depth;
  wire in_full = in_level >= in_depth;
  wire out_wr = wr_i && addr_i == `DSFE_A_OUTDATA;
  wire in_rd = rd_i && addr_i == `DSFE_A_INDATA && in_level != 0;

  // dma list count field (bits 5:4) 0..3 means 1, 2, 4 or 8 ports
  function [2:0] list_port;
    input [31:0] list;
    input dma;
    input [2:0] idx;
    begin
      if (dma)
        list_port = list[2:0] + idx; // see R13
      else
        list_port = list[{idx, 2'b00} +: 3];
    end
  endfunction
  function [2:0] list_last;
    input [31:0] list;
    input dma;
    begin
      if (dma)
        list_last = (3'd1 << list[5:4]) - 3'd1; // see R11
      else
        list_last = list[30:28];
    end
  endfunction

  dsfe_sample_tick u_out_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .enable_i(out_state_r == ST_RUN),
    .divider_i(divider_r),
    .floor_i(out_dma ? DMA_FLOOR[15:0] : LIST_FLOOR[15:0]), // see R11 see R12
    .tick_o(out_tick)
  );
  dsfe_sample_tick u_in_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .enable_i(in_state_r == ST_RUN),
    .divider_i(divider_r),
    .floor_i(in_dma ? DMA_FLOOR[15:0] : LIST_FLOOR[15:0]),
    .tick_o(in_tick)
  );

  wire [`DSFE_ENTRY_W-1:0] out_word = out_mem[out_rp_r[OUT_AW-1:0]];
  wire [2:0] out_port = out_tag ? out_word[`DSFE_TAG_HI:`DSFE_TAG_LO] :
    list_port(out_list_r, out_dma, out_idx_r); // see R8
  wire [2:0] in_port = list_port(in_list_r, in_dma, in_idx_r);
  wire out_go = out_tick && out_level != 0;
  wire in_go = in_tick && (!in_full || ctrl_r[`DSFE_C_OVERWRITE]);
  wire out_end = out_go && out_pos_r + 32'd1 >= buf_len_r;
  wire in_end = in_go && in_pos_r + 32'd1 >= buf_len_r;
  wire [`DSFE_ENTRY_W-1:0] in_sample = in_tag ?
    {5'h00, in_port, pin_stable_r[{in_port, 4'h0} +: 16]} :
    {8'h00, pin_stable_r[{in_port, 4'h0} +: 16]}; // see R9

  integer i;
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl_r <= 32'h0;
      port_direction_mask <= 8'h00; // see R21
      out_list_r <= 32'h0;
      in_list_r <= 32'h0;
      buf_len_r <= 32'h0;
      frame_len_r <= 32'h0;
      divider_r <= 16'h0;
      out_state_r <= ST_IDLE;
      in_state_r <= ST_IDLE;
      out_wp_r <= {(OUT_AW+1){1'b0}};
      out_rp_r <= {(OUT_AW+1){1'b0}};
      in_wp_r <= {(IN_AW+1){1'b0}};
      in_rp_r <= {(IN_AW+1){1'b0}};
      out_pos_r <= 32'h0;
      in_pos_r <= 32'h0;
      out_frame_r <= 32'h0;
      in_frame_r <= 32'h0;
      out_idx_r <= 3'd0;
      in_idx_r <= 3'd0;
      port_latch_r <= 128'h0;
      out_half_r <= 1'b0;
      in_half_r <= 1'b0;
      out_sticky_r <= 1'b0;
      in_sticky_r <= 1'b0;
      rdata_o <= 32'h0;
      port_pin_o <= 128'h0;
      port_pin_oe_o <= 128'h0;
      refill_req_o <= 1'b0;
      frame_complete_event_o <= 1'b0;
      buffer_complete_event_o <= 1'b0;
      run_halted_event_o <= 1'b0;
    end
    else
    begin
      refill_req_o <= 1'b0;
      frame_complete_event_o <= 1'b0;
      buffer_complete_event_o <= 1'b0;
      run_halted_event_o <= 1'b0;
      rdata_o <= 32'h0;
      if (wr_i)
      begin
        case (addr_i)
          `DSFE_A_CTRL: ctrl_r <= wdata_i;
          `DSFE_A_DIR: port_direction_mask <= wdata_i[7:0]; // see R6 see R7
          `DSFE_A_OUTLIST: out_list_r <= wdata_i;
          `DSFE_A_INLIST: in_list_r <= wdata_i;
          `DSFE_A_BUFLEN: buf_len_r <= wdata_i;
          `DSFE_A_FRAMELEN: frame_len_r <= wdata_i; // see R14
          `DSFE_A_DIVIDER: divider_r <= wdata_i[15:0];
          default: ;
        endcase
      end
      // start from an idle or halted engine; stop freezes fifos
      if (wr_i && addr_i == `DSFE_A_CTRL)
      begin
        if (wdata_i[`DSFE_C_OUT_RUN] && out_state_r != ST_RUN)
        begin
          out_state_r <= ST_RUN; // see R19 see R23
          out_pos_r <= 32'h0;
          out_frame_r <= 32'h0;
          out_idx_r <= 3'd0;
        end
        else if (!wdata_i[`DSFE_C_OUT_RUN])
          out_state_r <= ST_IDLE; // see R23
        if (wdata_i[`DSFE_C_IN_RUN] && in_state_r != ST_RUN)
        begin
          in_state_r <= ST_RUN;
          in_pos_r <= 32'h0;
          in_frame_r <= 32'h0;
          in_idx_r <= 3'd0;
        end
        else if (!wdata_i[`DSFE_C_IN_RUN])
          in_state_r <= ST_IDLE;
        if (wdata_i[`DSFE_C_CLEAR])
        begin
          out_wp_r <= {(OUT_AW+1){1'b0}};
          out_rp_r <= {(OUT_AW+1){1'b0}};
          in_wp_r <= {(IN_AW+1){1'b0}};
          in_rp_r <= {(IN_AW+1){1'b0}};
        end
      end
      // preload allowed in any state; full fifo drops the word
      if (out_wr && !out_full)
      begin
        out_mem[out_wp_r[OUT_AW-1:0]] <= wdata_i[`DSFE_ENTRY_W-1:0];
        out_wp_r <= out_wp_r + 1'b1;
      end
      if (out_go)
      begin
        port_latch_r[{out_port, 4'h0} +: 16] <= out_word[15:0]; // see R20
        out_rp_r <= out_rp_r + 1'b1;
        out_idx_r <= (out_idx_r >= list_last(out_list_r, out_dma)) ? 3'd0 : out_idx_r + 3'd1;
        if (out_frame_r + 32'd1 >= frame_len_r)
        begin
          out_frame_r <= 32'h0;
          frame_complete_event_o <= 1'b1; // see R15
        end
        else
          out_frame_r <= out_frame_r + 32'd1;
        if (out_end)
        begin
          out_pos_r <= 32'h0; // see R17
          buffer_complete_event_o <= 1'b1;
          if (!ctrl_r[`DSFE_C_WRAP])
          begin
            out_state_r <= ST_HALT; // see R16
            run_halted_event_o <= 1'b1;
          end
        end
        else
          out_pos_r <= out_pos_r + 32'd1;
      end
      if (in_go)
      begin
        in_mem[in_wp_r[IN_AW-1:0]] <= in_sample; // see R20
        in_wp_r <= in_wp_r + 1'b1;
        if (in_full)
          in_rp_r <= in_rp_r + 1'b1; // see R18
        in_idx_r <= (in_idx_r >= list_last(in_list_r, in_dma)) ? 3'd0 : in_idx_r + 3'd1;
        if (in_frame_r + 32'd1 >= frame_len_r)
        begin
          in_frame_r <= 32'h0;
          frame_complete_event_o <= 1'b1; // see R15
        end
        else
          in_frame_r <= in_frame_r + 32'd1;
        if (in_end)
        begin
          in_pos_r <= 32'h0; // see R17
          buffer_complete_event_o <= 1'b1;
          if (!ctrl_r[`DSFE_C_WRAP])
          begin
            in_state_r <= ST_HALT; // see R16
            run_halted_event_o <= 1'b1;
          end
        end
        else
          in_pos_r <= in_pos_r + 32'd1;
      end
      if (in_rd && !(in_go && in_full))
        in_rp_r <= in_rp_r + 1'b1;
      // one request per crossing; re-armed once the level moves back across half
      out_half_r <= out_level <= (out_depth >> 1);
      if (out_state_r == ST_RUN && out_level <= (out_depth >> 1) && !out_half_r)
        refill_req_o <= 1'b1; // see R1 see R22
      in_half_r <= in_level >= (in_depth >> 1);
      if (in_state_r == ST_RUN && in_level >= (in_depth >> 1) && !in_half_r)
        refill_req_o <= 1'b1; // see R1 see R22
      out_sticky_r <= out_sticky_r | (out_state_r == ST_HALT);
      in_sticky_r <= in_sticky_r | (in_state_r == ST_HALT);
      if (rd_i)
      begin
        case (addr_i)
          `DSFE_A_CTRL: rdata_o <= ctrl_r;
          `DSFE_A_DIR: rdata_o <= {24'h0, port_direction_mask};
          `DSFE_A_OUTLIST: rdata_o <= out_list_r;
          `DSFE_A_INLIST: rdata_o <= in_list_r;
          `DSFE_A_BUFLEN: rdata_o <= buf_len_r;
          `DSFE_A_FRAMELEN: rdata_o <= frame_len_r;
          `DSFE_A_INDATA: rdata_o <= {8'h00, in_mem[in_rp_r[IN_AW-1:0]]};
          `DSFE_A_STATUS: rdata_o <= {26'h0, in_sticky_r, out_sticky_r, in_state_r, out_state_r};
          `DSFE_A_LEVELS: rdata_o <= {in_level_x[15:0], out_level_x[15:0]};
          `DSFE_A_PORTIN: rdata_o <= pin_stable_r[{wdata_i[2:1], 5'h00} +: 32];
          `DSFE_A_DIVIDER: rdata_o <= {16'h0, divider_r};
          default: rdata_o <= 32'h0;
        endcase
      end
      // ports hold the latch while fifo empty or stopped
      port_pin_o <= port_latch_r; // see R2 see R23
      for (i = 0; i < `DSFE_NPORTS; i = i + 1)
        port_pin_oe_o[i*16 +: 16] <= {16{port_direction_mask[i]}}; // see R6
    end
  end

  // pin inputs: three stages, accept once stages two and three agree
  integer k;
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pin_s1_r <= 128'h0;
      pin_s2_r <= 128'h0;
      pin_s3_r <= 128'h0;
      pin_stable_r <= 128'h0;
    end
    else
    begin
      pin_s1_r <= port_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (k = 0; k < 128; k = k + 1)
        if (pin_s2_r[k] == pin_s3_r[k])
          pin_stable_r[k] <= pin_s3_r[k];
    end
  end
endmodule // dsfe_stream_engine

// ---- logic/dsfe_defines.vh ----
// constants for the digital i/o streaming fifo engine
`ifndef DSFE_DEFINES_VH
`define DSFE_DEFINES_VH
`define DSFE_CLK_KHZ 100000
`define DSFE_DMA_MAX_KHZ 1600
`define DSFE_LIST_MAX_KHZ 450
`define DSFE_OUT_DEPTH 2048
`define DSFE_OUT_DEPTH_EXT 65536
`define DSFE_IN_DEPTH 1024
`define DSFE_ENTRY_W 24
`define DSFE_PORT_W 16
`define DSFE_NPORTS 8
`define DSFE_MIN_FRAME_IN 512
`define DSFE_MIN_FRAME_OUT 1024
`define DSFE_TAG_LO 16
`define DSFE_TAG_HI 18
`define DSFE_CNT_W 24
`define DSFE_A_CTRL 4'h0
`define DSFE_A_DIR 4'h1
`define DSFE_A_OUTLIST 4'h2
`define DSFE_A_INLIST 4'h3
`define DSFE_A_BUFLEN 4'h4
`define DSFE_A_FRAMELEN 4'h5
`define DSFE_A_OUTDATA 4'h6
`define DSFE_A_INDATA 4'h7
`define DSFE_A_STATUS 4'h8
`define DSFE_A_LEVELS 4'h9
`define DSFE_A_PORTIN 4'ha
`define DSFE_A_DIVIDER 4'hb
`define DSFE_C_OUT_RUN 0
`define DSFE_C_IN_RUN 1
`define DSFE_C_WRAP 2
`define DSFE_C_OVERWRITE 3
`define DSFE_C_OUT_DMA 4
`define DSFE_C_IN_DMA 5
`define DSFE_C_TAGGED 6
`define DSFE_C_EXTMEM 7
`define DSFE_C_CLEAR 8
`endif

// ---- logic/dsfe_sample_tick.v ----
// sample clock divider producing one-cycle update enables
`timescale 1ns/10ps
module dsfe_sample_tick (
  input wire clk_i,
  input wire nrst_i,
  input wire enable_i,
  input wire [15:0] divider_i,
  input wire [15:0] floor_i,
  output reg tick_o
);
  reg [15:0] count_r;
  wire [15:0] limit;
  // never tick faster than the mode allows
  assign limit = (divider_i < floor_i) ? floor_i : divider_i;
  always @(posedge clk_i)
  begin
    if (!nrst_i || !enable_i)
    begin
      count_r <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (count_r + 16'h0001 >= limit)
    begin
      count_r <= 16'h0000;
      tick_o <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule // dsfe_sample_tick

// ---- verif/dsfe_stream_assertions.sv ----
// port-level checks for the streaming fifo engine
`timescale 1ns/10ps
`include "dsfe_defines.vh"
module dsfe_stream_assertions #(
  parameter OUT_AW = 16,
  parameter IN_AW = 10,
  parameter EXT_MEM = 1
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire [127:0] port_pin_i,
  input wire [127:0] port_pin_o,
  input wire [127:0] port_pin_oe_o,
  input wire refill_req_o,
  input wire frame_complete_event_o,
  input wire buffer_complete_event_o,
  input wire run_halted_event_o
);
  reg [8:0] ctrl_r;
  reg [7:0] gap_r;
  wire dir_wr = wr_i && (addr_i == `DSFE_A_DIR);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // gap saturates: only short spacings matter
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl_r <= 9'h0;
      gap_r <= 8'h0;
    end
    else
    begin
      if (wr_i && (addr_i == `DSFE_A_CTRL))
        ctrl_r <= wdata_i[8:0];
      gap_r <= $changed(port_pin_o) ? 8'h0 : ((gap_r == 8'hff) ? gap_r : gap_r + 8'h1);
    end
  end
  AST_RESET_INPUTS: assert property (disable iff (1'b0) !nrst_i |=>
    (port_pin_oe_o == 128'h0) && (port_pin_o == 128'h0)) else $error("ports not idle in reset");
  genvar k;
  for (k = 0; k < 8; k = k + 1)
  begin : g_dir
    AST_DIR_DRIVE: assert property (dir_wr |=> ##1
      port_pin_oe_o[16*k +: 16] == {16{$past(wdata_i[k], 2)}}) else $error("port enable wrong");
  end
  AST_OE_ONLY_ON_DIR: assert property (!$past(dir_wr, 2) |-> $stable(port_pin_oe_o))
    else $error("port enable moved alone");
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 32'h0) else $error("stray read data");
  AST_FRAME_PULSE: assert property (frame_complete_event_o |=> !frame_complete_event_o)
    else $error("frame event too long");
  AST_REFILL_ONCE: assert property (not (refill_req_o ##1 refill_req_o))
    else $error("refill request repeated");
  AST_END_HALTS: assert property (buffer_complete_event_o && !ctrl_r[`DSFE_C_WRAP]
    |-> ##[0:2] run_halted_event_o) else $error("buffer end without halt");
  AST_STOP_HOLDS: assert property ((!ctrl_r[`DSFE_C_OUT_RUN]) [*3] |=> $stable(port_pin_o))
    else $error("ports moved while stopped");
  AST_DMA_RATE: assert property ($changed(port_pin_o) && ctrl_r[`DSFE_C_OUT_DMA]
    |-> gap_r >= 8'd60) else $error("dma updates too close");
  AST_LIST_RATE: assert property ($changed(port_pin_o) && !ctrl_r[`DSFE_C_OUT_DMA]
    |-> gap_r >= 8'd220) else $error("list updates too close");
  cover property (buffer_complete_event_o);
  cover property (frame_complete_event_o);
  cover property ($changed(port_pin_o) && !ctrl_r[`DSFE_C_OUT_DMA]);
endmodule // dsfe_stream_assertions
bind dsfe_stream_engine dsfe_stream_assertions #(.OUT_AW(OUT_AW), .IN_AW(IN_AW),
  .EXT_MEM(EXT_MEM)) i_dsfe_stream_assertions (.clk_i(clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .port_pin_i(port_pin_i), .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
  .refill_req_o(refill_req_o), .frame_complete_event_o(frame_complete_event_o),
  .buffer_complete_event_o(buffer_complete_event_o),
  .run_halted_event_o(run_halted_event_o));

// ---- verif/dsfe_pin_partner.sv ----
// field-side model of the port lines
`timescale 1ns/10ps
module dsfe_pin_partner (
  input wire clk_i,
  input wire [127:0] port_pin_o,
  input wire [127:0] port_pin_oe_o,
  output wire [127:0] port_pin_i
);
  reg [127:0] ext_r = {4{32'h5a3c_96e1}};
  // undriven lines keep moving so a stale value never passes for data
  always @(posedge clk_i)
    ext_r <= ~{ext_r[126:0], ext_r[127]};
  assign port_pin_i = (port_pin_oe_o & port_pin_o) | (~port_pin_oe_o & ext_r);
endmodule // dsfe_pin_partner

// ---- verif/testbench.sv ----
// self-checking bench for the streaming fifo engine
`timescale 1ns/10ps
`include "dsfe_defines.vh"
module testbench;
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [31:0] rv;
  reg [15:0] p0_r = 16'h0;
  reg [15:0] seen [$];
  wire [31:0] rdata_o;
  wire [127:0] port_pin_i, port_pin_o, port_pin_oe_o;
  wire refill_req_o, frame_complete_event_o, buffer_complete_event_o, run_halted_event_o;
  integer miscompares = 0;
  integer n_compared = 0;
  integer n_frame = 0;
  integer n_done = 0;
  integer n_halt = 0;
  integer n_refill = 0;
  integer i;
  initial forever #5 clk_i = ~clk_i;
  // expansion memory strap off keeps the fifo at its standard depth
  dsfe_stream_engine #(.OUT_AW(12), .IN_AW(10), .EXT_MEM(0)) i_dsfe_stream_engine (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
    .port_pin_oe_o(port_pin_oe_o), .refill_req_o(refill_req_o),
    .frame_complete_event_o(frame_complete_event_o),
    .buffer_complete_event_o(buffer_complete_event_o),
    .run_halted_event_o(run_halted_event_o));
  dsfe_pin_partner i_dsfe_pin_partner (.clk_i(clk_i), .port_pin_o(port_pin_o),
    .port_pin_oe_o(port_pin_oe_o), .port_pin_i(port_pin_i));
  always @(posedge clk_i)
  begin
    p0_r <= port_pin_o[15:0];
    if (nrst_i && (port_pin_o[15:0] !== p0_r))
      seen.push_back(port_pin_o[15:0]);
    if (frame_complete_event_o === 1'b1)
      n_frame = n_frame + 1;
    if (buffer_complete_event_o === 1'b1)
      n_done = n_done + 1;
    if (run_halted_event_o === 1'b1)
      n_halt = n_halt + 1;
    if (refill_req_o === 1'b1)
      n_refill = n_refill + 1;
  end
  task wr(input [3:0] a, input [31:0] d);
  begin
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  end
  endtask
  task cmp(input string nm, input [31:0] exp, input [31:0] got);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  task wait_halt;
    integer k;
  begin
    k = 0;
    while (n_halt == 0 && k < 80000)
    begin
      @(posedge clk_i);
      k = k + 1;
    end
    #1 cmp("halt wait", 32'h1, n_halt);
  end
  endtask
  task finish_test;
  begin
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    #900000;
    miscompares = miscompares + 1;
    finish_test;
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    cmp("oe in reset", 32'h0, {31'h0, |port_pin_oe_o});
    nrst_i <= 1'b1;
    wr(`DSFE_A_DIR, 32'h5);
    // the mask reaches the enables one cycle after the write
    @(posedge clk_i);
    #1 cmp("oe low", 32'h0000ffff, port_pin_oe_o[31:0]);
    cmp("oe high", 32'h0000ffff, port_pin_oe_o[63:32]);
    rd(4'hf);
    // fixed-list run from port 0; tag bits set but must be ignored
    wr(`DSFE_A_CTRL, 32'h50);
    wr(`DSFE_A_OUTLIST, 32'h0);
    wr(`DSFE_A_DIVIDER, 32'h0);
    wr(`DSFE_A_BUFLEN, 32'd1024);
    wr(`DSFE_A_FRAMELEN, 32'd1024);
    // one word above half so the first pop crosses the refill level
    for (i = 0; i < 1025; i = i + 1)
      wr(`DSFE_A_OUTDATA, 32'h71000 + i);
    rd(`DSFE_A_LEVELS);
    cmp("levels", 32'h0000_0401, rv);
    seen.delete();
    n_halt = 0;
    wr(`DSFE_A_CTRL, 32'h51);
    wait_halt;
    cmp("refill", 32'h1, n_refill);
    cmp("updates", 32'd1024, seen.size());
    for (i = 0; i < 1024 && i < seen.size(); i = i + 1)
      cmp("port0 data", 32'h1000 + i, {16'h0, seen[i]});
    cmp("frames", 32'h1, n_frame);
    cmp("buffer done", 32'h1, n_done);
    repeat (100) @(posedge clk_i);
    #1 cmp("port0 hold", 32'h13ff, port_pin_o[15:0]);
    cmp("port7 idle", 32'h0, {16'h0, port_pin_o[127:112]});
    rd(`DSFE_A_STATUS);
    cmp("status", 32'h12, rv & 32'h13);
    // tagged list run; clear drops the word left from the first run
    wr(`DSFE_A_CTRL, 32'h140);
    wr(`DSFE_A_DIR, 32'h25);
    wr(`DSFE_A_OUTLIST, 32'h1000_0052);
    wr(`DSFE_A_BUFLEN, 32'd2);
    wr(`DSFE_A_FRAMELEN, 32'd1024);
    wr(`DSFE_A_OUTDATA, 32'h02abcd);
    wr(`DSFE_A_OUTDATA, 32'h051234);
    n_halt = 0;
    wr(`DSFE_A_CTRL, 32'h41);
    wait_halt;
    #1 cmp("port2", 32'habcd, port_pin_o[47:32]);
    cmp("port5", 32'h1234, port_pin_o[95:80]);
    cmp("port0 kept", 32'h13ff, port_pin_o[15:0]);
    cmp("refill once", 32'h1, n_refill);
    // input dma run samples the driven port 0 back through the pins
    wr(`DSFE_A_INLIST, 32'h0);
    n_halt = 0;
    wr(`DSFE_A_CTRL, 32'h22);
    wait_halt;
    rd(`DSFE_A_INDATA);
    cmp("input 0", 32'h13ff, rv);
    rd(`DSFE_A_INDATA);
    cmp("input 1", 32'h13ff, rv);
    rd(`DSFE_A_LEVELS);
    cmp("in level", 32'h0, rv);
    finish_test;
  end
endmodule // testbench
